// >>> pkg/sercfg_pkg.sv
// Constants, types and register layout for the serializer configuration bank.
// Assumes a single mclk domain; pins are synchronised in the core.
package sercfg_pkg;
  // Register offsets
  localparam logic [7:0] SERCFG_OFF_LINK_CONFIG = 8'h00;
  localparam logic [7:0] SERCFG_OFF_BUS_ADDR = 8'h01;
  localparam logic [7:0] SERCFG_OFF_TX_EMPH = 8'h02;
  // Field positions
  localparam int SERCFG_BIT_REG_CTRL = 0;
  localparam int SERCFG_BIT_SLEEP = 1;
  localparam int SERCFG_MODE_LSB = 2;
  localparam int SERCFG_BIT_SWING = 5;
  localparam int SERCFG_BIT_LANE_ORDER = 6;
  localparam int SERCFG_BIT_ADDR_SRC = 7;
  localparam int SERCFG_BIT_EMPH_DIS = 4;
  localparam int SERCFG_EMPH_LSB = 5;
  // Reset values
  localparam logic [7:0] SERCFG_RST_LINK_CONFIG = 8'h00;
  localparam logic [7:0] SERCFG_RST_BUS_ADDR = 8'h68;
  localparam logic [7:0] SERCFG_RST_TX_EMPH = 8'h00;
  // Writable bit masks, reserved bits read as zero
  localparam logic [7:0] SERCFG_MASK_LINK_CONFIG = 8'h6f;
  localparam logic [7:0] SERCFG_MASK_TX_EMPH = 8'hf0;
  // Valid bus addresses
  localparam logic [6:0] SERCFG_ADDR_A = 7'h69;
  localparam logic [6:0] SERCFG_ADDR_B = 7'h6a;
  localparam logic [6:0] SERCFG_ADDR_C = 7'h6b;
  localparam logic [6:0] SERCFG_ADDR_D = 7'h6e;
  localparam logic [3:0] SERCFG_BYTE_BITS = 4'h8;

  typedef enum logic [1:0] {
    SERCFG_NORMAL_NOFILT,
    SERCFG_NORMAL_FILT,
    SERCFG_COMPAT_GEN2,
    SERCFG_COMPAT_GEN1
  } sercfg_mode_type;

  typedef enum logic [3:0] {
    SERCFG_IDLE, SERCFG_ADDR, SERCFG_ADDR_ACK, SERCFG_PTR, SERCFG_PTR_ACK,
    SERCFG_WDATA, SERCFG_WACK, SERCFG_RDATA, SERCFG_RACK
  } sercfg_bus_state_type;

  typedef struct packed {
    sercfg_mode_type mode;
    logic filter_en;
    logic compat_gen2;
    logic compat_gen1;
    logic sleep;
    logic lane_bit_order;
    logic swing_select;
    logic deemph_on;
    logic deemph_ext;
    logic [2:0] deemph_level;
    logic [6:0] bus_addr;
  } sercfg_cfg_type;

  // Configuration output under reset: level 000 means external resistor
  localparam sercfg_cfg_type SERCFG_RST_CFG = '{
    mode: SERCFG_NORMAL_NOFILT, filter_en: 1'b0, compat_gen2: 1'b0,
    compat_gen1: 1'b0, sleep: 1'b0, lane_bit_order: 1'b0,
    swing_select: 1'b0, deemph_on: 1'b1, deemph_ext: 1'b1,
    deemph_level: 3'h0, bus_addr: 7'h00
  };
endpackage : sercfg_pkg

// >>> core/sercfg_regs.sv
// Serializer configuration registers behind a two-wire serial slave.
// Assumes open-drain bus pins resolved outside; straps are asynchronous pins.
// Summary of operation
// - Mode comes from two strap pins or register field, same encoding.
// - Mode 00 normal without filter, 01 normal with filter; resets 00.
// - Mode 10 second-generation legacy, 11 first-generation legacy link.
// - Config bit 0 picks pins or registers; bus address excluded.
// - Config bit 1 sleeps the device, registers kept; not power-down.
// - Address bit 7 picks strap address or register address field.
// - Address field resets 1101000; only four valid addresses accepted.
// - De-emphasis 000 uses external resistor, 001..111 fixed levels.
// - Host reaches registers over two-wire bus, device as slave.
module sercfg_regs
  import sercfg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] mode_strap,
  input wire logic lane_bit_order_strap,
  input wire logic swing_select_strap,
  input wire logic [6:0] bus_addr_strap,
  output sercfg_cfg_type cfg
);
  logic [10:0] pin_s1_reg, pin_s2_reg;
  logic [1:0] bus_s1_reg, bus_s2_reg, bus_s3_reg;
  sercfg_bus_state_type state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg, ptr_reg;
  logic rw_reg, oe_reg;
  logic [7:0] link_config_reg, bus_addr_reg, tx_emph_reg;
  sercfg_cfg_type cfg_reg;

  // Synchronisers: first stage read only by second
  always_ff @(posedge mclk) begin
    pin_s1_reg <= {mode_strap, lane_bit_order_strap, swing_select_strap,
                   bus_addr_strap};
    pin_s2_reg <= pin_s1_reg;
    bus_s1_reg <= {scl_in, sda_in};
    bus_s2_reg <= bus_s1_reg;
    bus_s3_reg <= bus_s2_reg;
  end

  wire [1:0] mode_pin = pin_s2_reg[10:9];
  wire lane_pin = pin_s2_reg[8];
  wire swing_pin = pin_s2_reg[7];
  wire [6:0] addr_pin = pin_s2_reg[6:0];
  wire scl = bus_s2_reg[1];
  wire sda = bus_s2_reg[0];
  wire scl_rise = scl && !bus_s3_reg[1];
  wire scl_fall = !scl && bus_s3_reg[1];
  wire start_det = scl && bus_s3_reg[1] && !sda && bus_s3_reg[0];
  wire stop_det = scl && bus_s3_reg[1] && sda && !bus_s3_reg[0];
  wire byte_full = (cnt_reg == SERCFG_BYTE_BITS);

  // Address source select
  wire [6:0] active_addr = bus_addr_reg[SERCFG_BIT_ADDR_SRC] ?
                           bus_addr_reg[6:0] : addr_pin;
  wire addr_hit = (sh_reg[7:1] == active_addr);
  wire wr_fire = scl_fall && state_reg == SERCFG_WDATA && byte_full;
  wire [6:0] wr_addr = sh_reg[6:0];
  wire addr_ok = wr_addr == SERCFG_ADDR_A || wr_addr == SERCFG_ADDR_B ||
                 wr_addr == SERCFG_ADDR_C || wr_addr == SERCFG_ADDR_D;
  wire [7:0] rdata = (ptr_reg == SERCFG_OFF_LINK_CONFIG) ? link_config_reg :
                     (ptr_reg == SERCFG_OFF_BUS_ADDR) ? bus_addr_reg :
                     (ptr_reg == SERCFG_OFF_TX_EMPH) ? tx_emph_reg : 8'h00;

  // Serial slave engine
  always_ff @(posedge mclk) begin
    if (!rst_n || stop_det) begin
      state_reg <= SERCFG_IDLE;
      oe_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end else if (start_det) begin
      state_reg <= SERCFG_ADDR;
      oe_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end else if (scl_rise) begin
      unique case (state_reg)
        SERCFG_ADDR, SERCFG_PTR, SERCFG_WDATA: begin
          sh_reg <= {sh_reg[6:0], sda};
          cnt_reg <= cnt_reg + 4'h1;
        end
        SERCFG_RDATA: cnt_reg <= cnt_reg + 4'h1;
        SERCFG_RACK: if (sda) state_reg <= SERCFG_IDLE;
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (state_reg)
        SERCFG_ADDR: if (byte_full) begin
          if (addr_hit) begin
            oe_reg <= 1'b1;
            rw_reg <= sh_reg[0];
            state_reg <= SERCFG_ADDR_ACK;
          end else begin
            state_reg <= SERCFG_IDLE;
          end
        end
        SERCFG_ADDR_ACK, SERCFG_RACK: begin
          cnt_reg <= 4'h0;
          if (state_reg == SERCFG_RACK || rw_reg) begin
            sh_reg <= rdata;
            oe_reg <= !rdata[7];
            ptr_reg <= ptr_reg + 8'h01;
            state_reg <= SERCFG_RDATA;
          end else begin
            oe_reg <= 1'b0;
            state_reg <= SERCFG_PTR;
          end
        end
        SERCFG_PTR: if (byte_full) begin
          ptr_reg <= sh_reg;
          oe_reg <= 1'b1;
          state_reg <= SERCFG_PTR_ACK;
        end
        SERCFG_PTR_ACK, SERCFG_WACK: begin
          oe_reg <= 1'b0;
          cnt_reg <= 4'h0;
          state_reg <= SERCFG_WDATA;
        end
        SERCFG_WDATA: if (byte_full) begin
          ptr_reg <= ptr_reg + 8'h01;
          oe_reg <= 1'b1;
          state_reg <= SERCFG_WACK;
        end
        SERCFG_RDATA: begin
          if (byte_full) begin
            oe_reg <= 1'b0;
            state_reg <= SERCFG_RACK;
          end else begin
            oe_reg <= !sh_reg[6];
            sh_reg <= {sh_reg[6:0], 1'b0};
          end
        end
        default: ;
      endcase
    end
  end

  // Register bank; sleep keeps contents
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      link_config_reg <= SERCFG_RST_LINK_CONFIG;
      bus_addr_reg <= SERCFG_RST_BUS_ADDR;
      tx_emph_reg <= SERCFG_RST_TX_EMPH;
    end else if (wr_fire) begin
      if (ptr_reg == SERCFG_OFF_LINK_CONFIG)
        link_config_reg <= sh_reg & SERCFG_MASK_LINK_CONFIG;
      if (ptr_reg == SERCFG_OFF_BUS_ADDR) begin
        bus_addr_reg[SERCFG_BIT_ADDR_SRC] <= sh_reg[SERCFG_BIT_ADDR_SRC];
        if (addr_ok)
          bus_addr_reg[6:0] <= wr_addr;
      end
      if (ptr_reg == SERCFG_OFF_TX_EMPH)
        tx_emph_reg <= sh_reg & SERCFG_MASK_TX_EMPH;
    end
  end

  // Configuration source and mode decode
  wire reg_ctrl = link_config_reg[SERCFG_BIT_REG_CTRL];
  wire [1:0] mode_bits = reg_ctrl ?
      link_config_reg[SERCFG_MODE_LSB +: 2] : mode_pin;
  wire [2:0] emph_bits = reg_ctrl ? tx_emph_reg[SERCFG_EMPH_LSB +: 3] : 3'h0;
  sercfg_cfg_type cfg_next;
  always_comb begin
    cfg_next.mode = sercfg_mode_type'(mode_bits);
    cfg_next.filter_en = (mode_bits == 2'h1);
    cfg_next.compat_gen2 = (mode_bits == 2'h2);
    cfg_next.compat_gen1 = (mode_bits == 2'h3);
    cfg_next.sleep = link_config_reg[SERCFG_BIT_SLEEP];
    cfg_next.lane_bit_order = reg_ctrl ?
        link_config_reg[SERCFG_BIT_LANE_ORDER] : lane_pin;
    cfg_next.swing_select = reg_ctrl ?
        link_config_reg[SERCFG_BIT_SWING] : swing_pin;
    cfg_next.deemph_on =
        !(reg_ctrl && tx_emph_reg[SERCFG_BIT_EMPH_DIS]);
    cfg_next.deemph_ext = (emph_bits == 3'h0);
    cfg_next.deemph_level = emph_bits;
    cfg_next.bus_addr = active_addr;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n)
      cfg_reg <= SERCFG_RST_CFG;
    else
      cfg_reg <= cfg_next;
  end

  assign cfg = cfg_reg;
  assign sda_out = 1'b0;
  assign sda_oe = oe_reg;

  a_mode_from_reg: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_ctrl && $stable(link_config_reg) |=>
    cfg_reg.mode == $past(link_config_reg[3:2]))
    else $error("mode not taken from register");
  a_mode_from_pin: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !reg_ctrl |=> cfg_reg.mode == $past(mode_pin))
    else $error("mode not taken from straps");
  a_filter_mode: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cfg_reg.filter_en == (cfg_reg.mode == SERCFG_NORMAL_FILT))
    else $error("filter enable does not match mode");
  a_legacy_modes: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (cfg_reg.compat_gen1 || cfg_reg.compat_gen2) |->
    !cfg_reg.filter_en && cfg_reg.mode[1])
    else $error("legacy mode decode wrong");
  a_sleep_keeps: assert property (
    @(posedge mclk) disable iff (!rst_n)
    link_config_reg[SERCFG_BIT_SLEEP] && !wr_fire |=>
    $stable(tx_emph_reg) && $stable(bus_addr_reg) && cfg_reg.sleep)
    else $error("sleep lost state");
  a_addr_match: assert property (
    @(posedge mclk) disable iff (!rst_n)
    state_reg == SERCFG_ADDR && scl_fall && byte_full &&
    sh_reg[7:1] != active_addr |=> !oe_reg)
    else $error("acknowledged a foreign address");
  a_addr_field: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wr_fire && ptr_reg == SERCFG_OFF_BUS_ADDR && !addr_ok |=>
    $stable(bus_addr_reg[6:0]))
    else $error("reserved address accepted");
  a_emph_ext: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cfg_reg.deemph_ext == (cfg_reg.deemph_level == 3'h0))
    else $error("external de-emphasis decode wrong");
  a_emph_sense: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reg_ctrl && tx_emph_reg[SERCFG_BIT_EMPH_DIS] ##1
    $stable(tx_emph_reg) && reg_ctrl |-> !cfg_reg.deemph_on)
    else $error("de-emphasis sense inverted");
  a_write_ack: assert property (
    @(posedge mclk) disable iff (!rst_n)
    wr_fire && !start_det |=> oe_reg && state_reg == SERCFG_WACK)
    else $error("data byte not acknowledged");
endmodule : sercfg_regs

// >>> dv/sercfg_host.sv
// Behavioural two-wire bus master for the serializer configuration bank.
// Assumes the bench resolves the open-drain data line with a pull-up.
module sercfg_host (
  input wire logic mclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic half();
    repeat (6) @(posedge mclk);
  endtask : half
  // Data moves only while clock low
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    half();
    scl <= 1'b1;
    half();
    r = sda_line;
    scl <= 1'b0;
    half();
  endtask : bit_io
  task automatic start();
    sda_low <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl <= 1'b0;
    half();
  endtask : start
  task automatic stop();
    sda_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask : stop
  // Byte out MSB first, ninth bit released
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                      output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(1'b1, nak);
  endtask : xfer
  task automatic wr(input logic [6:0] a, input logic [7:0] off, d,
                    output logic ok);
    logic [7:0] q;
    logic n0, n1, n2;
    start();
    xfer({a, 1'b0}, q, n0);
    xfer(off, q, n1);
    xfer(d, q, n2);
    stop();
    ok = !(n0 | n1 | n2);
  endtask : wr
  // Read ends with master not-acknowledge
  task automatic rd(input logic [6:0] a, input logic [7:0] off,
                    output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic n0, n1, n2, n3;
    start();
    xfer({a, 1'b0}, q, n0);
    xfer(off, q, n1);
    start();
    xfer({a, 1'b1}, q, n2);
    xfer(8'hff, d, n3);
    stop();
    ok = !(n0 | n1 | n2);
  endtask : rd
endmodule : sercfg_host

// >>> dv/testbench.sv
// Self-checking bench for the serializer configuration bank.
// Assumes the design core and the behavioural bus master model.
module testbench import sercfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sda_low, sda_oe, sda_out, sda_in, ok, lane_s, swing_s;
  logic [1:0] mode_strap = 2'h0;
  logic [6:0] addr_strap = 7'h69;
  logic [7:0] rdat;
  sercfg_cfg_type cfg;
  int miscompares = 0;
  int cmp_count = 0;
  initial lane_s = 1'b0;
  initial swing_s = 1'b0;
  assign sda_in = !sda_low && (sda_oe ? sda_out : 1'b1);
  always #12.5 mclk = !mclk;
  sercfg_regs i_dut (.mclk(mclk), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .mode_strap(mode_strap), .lane_bit_order_strap(lane_s),
    .swing_select_strap(swing_s), .bus_addr_strap(addr_strap), .cfg(cfg));
  sercfg_host i_host (.mclk(mclk), .sda_line(sda_in), .scl(scl),
    .sda_low(sda_low));
  task automatic chk(input logic [7:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("Mismatches %0d, compares %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [6:0] a, input logic [7:0] off, d);
    i_host.wr(a, off, d, ok);
    chk({7'h0, ok}, 8'h01, "write ack");
    repeat (3) @(posedge mclk);
  endtask : wr
  task automatic rdchk(input logic [6:0] a, input logic [7:0] off, exp);
    i_host.rd(a, off, rdat, ok);
    chk({7'h0, ok}, 8'h01, "read ack");
    chk(rdat, exp, "read data");
  endtask : rdchk
  task automatic chk_mode(input logic [1:0] m);
    chk({6'h0, cfg.mode}, {6'h0, m}, "mode");
    chk({5'h0, cfg.filter_en, cfg.compat_gen2, cfg.compat_gen1},
      {5'h0, m == 2'b01, m == 2'b10, m == 2'b11}, "mode flags");
  endtask : chk_mode
  task automatic t_reset();
    rdchk(7'h69, 8'h00, 8'h00);
    rdchk(7'h69, 8'h01, 8'h68);
    rdchk(7'h69, 8'h02, 8'h00);
    rdchk(7'h69, 8'h03, 8'h00);
  endtask : t_reset
  task automatic t_pins();
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk);
      mode_strap <= m[1:0];
      lane_s <= m[0];
      swing_s <= m[1];
      repeat (5) @(posedge mclk);
      chk_mode(m[1:0]);
      chk({4'h0, cfg.lane_bit_order, cfg.swing_select, cfg.deemph_ext,
        cfg.deemph_on}, {4'h0, m[0], m[1], 2'b11}, "pin config");
    end
  endtask : t_pins
  task automatic t_regmode();
    for (int m = 0; m < 4; m++) begin
      wr(7'h69, 8'h00, {1'b0, m[1], m[0], 1'b0, m[1:0], 2'b01});
      chk_mode(m[1:0]);
      chk({6'h0, cfg.lane_bit_order, cfg.swing_select}, {6'h0, m[1], m[0]},
        "register config");
    end
    wr(7'h69, 8'h00, 8'h93);
    chk({7'h0, cfg.sleep}, 8'h01, "sleep");
    rdchk(7'h69, 8'h00, 8'h03);
    wr(7'h69, 8'h00, 8'h01);
    chk({7'h0, cfg.sleep}, 8'h00, "wake");
  endtask : t_regmode
  task automatic t_emph();
    for (int l = 0; l < 8; l++) begin
      for (int b = 0; b < 2; b++) begin
        wr(7'h69, 8'h02, {l[2:0], b[0], 4'hf});
        chk({3'h0, cfg.deemph_level, cfg.deemph_ext, cfg.deemph_on},
          {3'h0, l[2:0], l == 0, b == 0}, "emphasis");
      end
    end
    rdchk(7'h69, 8'h02, 8'hf0);
  endtask : t_emph
  task automatic t_addr();
    wr(7'h69, 8'h01, 8'heb);
    rdchk(7'h6b, 8'h01, 8'heb);
    chk({1'b0, cfg.bus_addr}, 8'h6b, "register address");
    i_host.rd(7'h69, 8'h01, rdat, ok);
    chk({7'h0, ok}, 8'h00, "old address refused");
    wr(7'h6b, 8'h01, 8'h85);
    rdchk(7'h6b, 8'h01, 8'heb);
    wr(7'h6b, 8'h01, 8'h6e);
    rdchk(7'h69, 8'h01, 8'h6e);
    chk({1'b0, cfg.bus_addr}, 8'h69, "strap address");
    @(posedge mclk);
    addr_strap <= 7'h6a;
    repeat (5) @(posedge mclk);
    chk({1'b0, cfg.bus_addr}, 8'h6a, "new strap address");
    rdchk(7'h6a, 8'h01, 8'h6e);
  endtask : t_addr
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    t_reset();
    t_pins();
    t_regmode();
    t_emph();
    t_addr();
    conclude();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    $display("BAD %0t run limit reached", $time);
    conclude();
  end
endmodule : testbench
